/* dsma_buf.sv */
// Purpose: shared constants and types, and the two-entry result buffer
// Assumes: one clock, synchronous active-high reset, clock enable freezes all state
// Notes: the buffer lets the fabric stall results without losing a word
// How it works
// RULE_01 - Signed operands and results are two's complement
// RULE_02 - Unit multiplies two pairs, adds, 37-bit P
// RULE_03 - Four two-multiplier units, eight multipliers
// RULE_04 - Four-multiplier sum gives 38-bit Z
// RULE_05 - Accumulator adds or subtracts Z into 44 bits
// RULE_06 - Accumulate and loopback keep a feedback register
// RULE_07 - Chain adder adds previous half's 44-bit result
// RULE_08 - A inputs can form a tap delay line
// RULE_09 - Round/saturate only in permitted modes
// RULE_10 - Shift operation selectable every clock cycle
// RULE_11 - Shifter takes 32-bit vector, two per block
// RULE_12 - Independent multipliers: 9, 12, 18, 36 bits
// RULE_13 - Two-multiplier adder: unsigned result must fit 36
// RULE_14 - At most two loopback multipliers per block
// RULE_15 - Mode set; chain adder only in sum modes
// RULE_16 - Halves run independent modes, shared clocking
// RULE_17 - Rising edge registers, cleared on reset
// RULE_18 - Sign control high means signed operand
// RULE_19 - Add/subtract choice static while running

// ----------------------------------------------------------------
// Package
// ----------------------------------------------------------------
package dsma_pkg;
  localparam int OPW = 18;
  localparam int NHALF = 2;
  localparam int NLANE = 4;
  localparam int PW = 37;
  localparam int ZW = 38;
  localparam int WW = 44;
  localparam int SHW = 32;
  localparam int RESW = NLANE * WW;
  localparam int BUFW = NHALF * RESW + 2 * NHALF;
  localparam int AW = 8;
  localparam int DW = 32;
  localparam int LOOP_LSB = WW - OPW;
  localparam logic [AW-1:0] OFS_CFG0 = 8'h00;
  localparam logic [AW-1:0] OFS_CFG1 = 8'h04;
  localparam logic [AW-1:0] OFS_CTRL = 8'h08;
  localparam logic [AW-1:0] OFS_STATUS = 8'h0C;
  localparam logic [AW-1:0] OFS_ACC0 = 8'h10;
  localparam logic [AW-1:0] OFS_ACC1 = 8'h14;
  localparam logic [DW-1:0] CFG_RST = 32'h0000_0000;
  localparam int F_MODE = 0;
  localparam int F_WID = 3;
  localparam int F_SUB0 = 5;
  localparam int F_SUB1 = 6;
  localparam int F_ACCSUB = 7;
  localparam int F_RSU = 8;
  localparam int F_RND = 9;
  localparam int F_SAT = 10;
  localparam int F_CHAIN = 11;
  localparam int F_LOOP = 12;
  localparam int F_TAP = 13;
  localparam int F_DROP = 16;
  localparam int C_RUN = 0;
  localparam int C_ACCCLR = 1;
  localparam int S_ACC = 1;
  localparam int S_SAT = 3;
  localparam logic signed [WW:0] SAT_MAX = 45'sh0007_FFFF_FFFF;
  localparam logic signed [WW:0] SAT_MIN = 45'sh1FF8_0000_0000;
  typedef enum logic [2:0] {MD_INDEP, MD_TWO_ADD, MD_FOUR_ADD, MD_MAC, MD_SHIFT,
    MD_HIPREC} dsma_mode_t;
  typedef enum logic [1:0] {WD_9, WD_12, WD_18, WD_36} dsma_width_t;
  typedef enum logic [2:0] {SH_LSL, SH_LSR, SH_ASL, SH_ASR, SH_ROL, SH_ROR} dsma_shop_t;
endpackage : dsma_pkg

`timescale 1ns/1ps
// ----------------------------------------------------------------
// Two-entry buffer: main output register plus one skid entry
// ----------------------------------------------------------------
module dsma_buf
  import dsma_pkg::*;
#(
  parameter int WIDTH = BUFW
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] din,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] main_ff;
  logic [WIDTH-1:0] skid_ff;
  logic main_v_ff;
  logic skid_v_ff;
  wire push = in_valid & in_ready;
  wire pop = main_v_ff & out_ready;
  wire main_free = pop | ~main_v_ff;

  // Ready depends only on the skid entry, so no path from out_ready
  assign in_ready = ~skid_v_ff;
  assign out_valid = main_v_ff;
  assign dout = main_ff;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      main_ff <= '0;
      skid_ff <= '0;
      main_v_ff <= 1'b0;
      skid_v_ff <= 1'b0;
    end else if (clk_en) begin
      if (main_free) begin
        main_ff <= skid_v_ff ? skid_ff : (push ? din : main_ff);
        main_v_ff <= skid_v_ff | push;
        if (skid_v_ff && push) begin
          skid_ff <= din;
        end else begin
          skid_v_ff <= 1'b0;
        end
      end else if (push) begin
        skid_ff <= din;
        skid_v_ff <= 1'b1;
      end
    end
  end

  a_buf_hold: assert property (@(posedge clk) disable iff (sys_rst)
    out_valid && !out_ready |=> out_valid && $stable(dout))
    else $error("buffer dropped a stalled word");
  a_buf_skid_fill: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && push && main_v_ff && !pop |=> skid_v_ff && !in_ready)
    else $error("buffer lost a word under stall");
endmodule : dsma_buf

/* dsma_block.sv */
// Purpose: two-half multiply-add datapath with accumulate, chain, shift and round/saturate
// Assumes: operands arrive from logic on the same clock; no synchronisers needed
// Notes: one result word per accepted operand set, one cycle after acceptance when the buffer's main entry is free
`timescale 1ns/1ps
module dsma_block
  import dsma_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [AW-1:0] reg_addr,
  input wire logic [DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DW-1:0] reg_rdata,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [NHALF*NLANE*OPW-1:0] op_a,
  input wire logic [NHALF*NLANE*OPW-1:0] op_b,
  input wire logic [NHALF-1:0] sign_a,
  input wire logic [NHALF-1:0] sign_b,
  input wire logic [NHALF*3-1:0] shift_op,
  input wire logic [WW-1:0] chain_in,
  output logic [WW-1:0] chain_out,
  output logic out_valid,
  input wire logic out_ready,
  output logic [NHALF*RESW-1:0] out_res,
  output logic [NHALF-1:0] out_sat_ovf,
  output logic [NHALF-1:0] out_acc_ovf
);
  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  function automatic logic signed [OPW:0] ext_op(input logic [OPW-1:0] x, input logic sgn,
                                                 input dsma_width_t w);
    logic signed [OPW:0] r;
    r = '0;
    case (w)
      WD_9: r = {{10{sgn & x[8]}}, x[8:0]};
      WD_12: r = {{7{sgn & x[11]}}, x[11:0]};
      default: r = {sgn & x[OPW-1], x};
    endcase
    return r;
  endfunction : ext_op

  function automatic logic [SHW-1:0] shift_fn(input logic [SHW-1:0] d, input logic [4:0] n,
                                              input dsma_shop_t op);
    logic [2*SHW-1:0] dd;
    logic [SHW-1:0] r;
    dd = '0;
    r = '0;
    case (op)
      SH_LSL, SH_ASL: r = d << n;
      SH_LSR: r = d >> n;
      SH_ASR: r = $signed(d) >>> n;
      SH_ROL: begin
        dd = {d, d} << n;
        r = dd[2*SHW-1:SHW];
      end
      SH_ROR: begin
        dd = {d, d} >> n;
        r = dd[SHW-1:0];
      end
      default: r = d;
    endcase
    return r;
  endfunction : shift_fn

  // Result is {overflow, value}; rounding clears the dropped low bits
  function automatic logic [WW:0] rsu_fn(input logic [WW-1:0] v, input logic [4:0] drop,
                                         input logic rnd, input logic sat);
    logic signed [WW:0] r;
    logic [WW:0] mask;
    logic [WW:0] o;
    r = {v[WW-1], v};
    mask = ~((45'h1 << drop) - 45'h1);
    if (rnd && drop != 5'h0) begin
      r = r + (45'sh1 <<< (drop - 5'h1));
    end
    r = r & mask;
    if (sat && r > SAT_MAX) begin
      o = {1'b1, SAT_MAX[WW-1:0]};
    end else if (sat && r < SAT_MIN) begin
      o = {1'b1, SAT_MIN[WW-1:0]};
    end else begin
      o = {1'b0, r[WW-1:0]};
    end
    return o;
  endfunction : rsu_fn

  // ----------------------------------------------------------------
  // Register file decode
  // ----------------------------------------------------------------
  logic [NHALF-1:0][DW-1:0] cfg_ff;
  logic run_ff;
  logic [NHALF-1:0] acc_stky_ff;
  logic [NHALF-1:0] sat_stky_ff;
  logic [DW-1:0] rdata_ff;
  logic [NHALF-1:0][WW-1:0] w_ff;
  logic [NHALF*NLANE-1:0][OPW-1:0] tap_ff;
  logic [WW-1:0] chain_ff;

  wire hit_cfg0 = reg_addr == OFS_CFG0;
  wire hit_cfg1 = reg_addr == OFS_CFG1;
  wire hit_ctrl = reg_addr == OFS_CTRL;
  wire hit_stat = reg_addr == OFS_STATUS;
  wire hit_acc0 = reg_addr == OFS_ACC0;
  wire hit_acc1 = reg_addr == OFS_ACC1;
  wire wr_ctrl = reg_wr & hit_ctrl;
  wire acc_clr = wr_ctrl & reg_wdata[C_ACCCLR];
  // Configuration is only accepted while stopped, so add/subtract cannot change mid-stream
  wire cfg_wr_ok = reg_wr & ~run_ff; // RULE_19
  wire [DW-1:0] stat_word = {27'h0, sat_stky_ff, acc_stky_ff, run_ff};
  wire [DW-1:0] rd_mux = hit_cfg0 ? cfg_ff[0] :
                         hit_cfg1 ? cfg_ff[1] :
                         hit_ctrl ? {31'h0, run_ff} :
                         hit_stat ? stat_word :
                         hit_acc0 ? w_ff[0][DW-1:0] :
                         hit_acc1 ? w_ff[1][DW-1:0] : 32'h0000_0000;

  // ----------------------------------------------------------------
  // Handshake
  // ----------------------------------------------------------------
  logic buf_in_ready;
  assign in_ready = run_ff & buf_in_ready;
  wire accept = in_valid & in_ready & clk_en;

  // ----------------------------------------------------------------
  // Datapath, one generate pass per half
  // ----------------------------------------------------------------
  wire [NHALF*NLANE-1:0][OPW-1:0] a_sel;
  wire [NHALF-1:0][WW-1:0] w_next;
  wire [NHALF-1:0][WW-1:0] zx;
  wire [NHALF-1:0][WW-1:0] chain_sum;
  wire [NHALF-1:0][RESW-1:0] res;
  wire [NHALF-1:0] is_mac;
  wire [NHALF-1:0] acc_sub;
  wire [NHALF-1:0] acc_ovf;
  wire [NHALF-1:0] sat_ovf;
  wire [NHALF-1:0][OPW-1:0] b0_sel;

  // Halves share clock, enable, reset, run and accumulator clear; each keeps its own mode
  for (genvar h = 0; h < NHALF; h++) begin : g_half // RULE_16
    wire [DW-1:0] cfg = cfg_ff[h];
    dsma_mode_t mode;
    dsma_width_t wid;
    dsma_width_t wid_eff;
    assign mode = dsma_mode_t'(cfg[F_MODE +: 3]);
    assign wid = dsma_width_t'(cfg[F_WID +: 2]);
    assign wid_eff = (mode == MD_INDEP) ? wid : WD_18;
    wire sum_mode = (mode == MD_FOUR_ADD) | (mode == MD_MAC);
    wire [NLANE-1:0][ZW-1:0] prod;
    wire [NLANE-1:0][OPW-1:0] b_sel;

    for (genvar k = 0; k < NLANE; k++) begin : g_lane // RULE_03
      localparam int G = h * NLANE + k;
      wire [OPW-1:0] a_raw = op_a[G*OPW +: OPW];
      wire [OPW-1:0] b_raw = op_b[G*OPW +: OPW];
      if (G == 0) begin : g_first
        assign a_sel[G] = a_raw;
      end else begin : g_tap
        assign a_sel[G] = cfg[F_TAP] ? tap_ff[G-1] : a_raw; // RULE_08
      end
      if (k == 0) begin : g_loop
        // Loopback reads the registered accumulator, one per half, two per block
        assign b_sel[k] = cfg[F_LOOP] ? w_ff[h][WW-1:LOOP_LSB] : b_raw; // RULE_14 RULE_06
      end else begin : g_direct
        assign b_sel[k] = b_raw;
      end
      wire signed [OPW:0] ea = ext_op(a_sel[G], sign_a[h], wid_eff); // RULE_01
      wire signed [OPW:0] eb = ext_op(b_sel[k], sign_b[h], wid_eff);
      wire signed [ZW-1:0] pr = ea * eb;
      wire lane_off = (mode == MD_INDEP) && (wid == WD_12) && (k == NLANE - 1); // RULE_12
      assign prod[k] = lane_off ? '0 : pr;
    end
    assign b0_sel[h] = b_sel[0];

    // Each unit keeps 37 bits; unsigned use must fit 36 bits
    wire [ZW-1:0] s0 = cfg[F_SUB0] ? prod[0] - prod[1] : prod[0] + prod[1]; // RULE_02
    wire [ZW-1:0] s1 = cfg[F_SUB1] ? prod[2] - prod[3] : prod[2] + prod[3];
    wire [PW-1:0] p0 = s0[PW-1:0]; // RULE_13
    wire [PW-1:0] p1 = s1[PW-1:0];
    wire [ZW-1:0] z = {p0[PW-1], p0} + {p1[PW-1], p1}; // RULE_04
    assign zx[h] = {{(WW-ZW){z[ZW-1]}}, z};
    assign acc_sub[h] = cfg[F_ACCSUB];
    assign is_mac[h] = mode == MD_MAC;
    assign w_next[h] = acc_sub[h] ? w_ff[h] - zx[h] : w_ff[h] + zx[h]; // RULE_05
    wire same_sign = w_ff[h][WW-1] == (zx[h][WW-1] ^ acc_sub[h]);
    assign acc_ovf[h] = is_mac[h] & same_sign & (w_next[h][WW-1] != w_ff[h][WW-1]);

    // Second stage only adds in four-multiplier mode; accumulate adds or subtracts
    wire [WW-1:0] pre = is_mac[h] ? w_next[h] : zx[h]; // RULE_15
    // The first half takes the chain from outside, so no loop forms through itself
    wire [WW-1:0] chain_src;
    if (h == 0) begin : g_chain_first
      assign chain_src = chain_in;
    end else begin : g_chain_next
      assign chain_src = chain_sum[h-1];
    end
    assign chain_sum[h] = (cfg[F_CHAIN] & sum_mode) ? pre + chain_src : pre; // RULE_07

    wire [OPW-1:0] a0 = a_sel[h*NLANE];
    wire [OPW-1:0] a1 = a_sel[h*NLANE+1];
    wire [OPW-1:0] a2 = a_sel[h*NLANE+2];
    wire signed [2*OPW:0] a36 = {sign_a[h] & a1[OPW-1], a1, a0};
    wire signed [2*OPW:0] b01 = {sign_b[h] & b_sel[1][OPW-1], b_sel[1], b_sel[0]};
    wire signed [2*OPW:0] b23 = {sign_b[h] & b_sel[3][OPW-1], b_sel[3], b_sel[2]};
    wire signed [OPW:0] a0e = {sign_a[h] & a0[OPW-1], a0};
    wire signed [OPW:0] a2e = {sign_a[h] & a2[OPW-1], a2};
    wire signed [4*OPW+1:0] p72 = a36 * b01; // RULE_12
    wire signed [3*OPW+1:0] hp0 = a0e * b01;
    wire signed [3*OPW+1:0] hp1 = a2e * b23;
    wire [3*OPW+1:0] h55 = hp0 + hp1;
    wire [SHW-1:0] shres = shift_fn({a1[OPW-3:0], a0[OPW-3:0]}, b_sel[0][4:0],
                                    dsma_shop_t'(shift_op[h*3 +: 3])); // RULE_10 RULE_11

    logic [NLANE-1:0][WW-1:0] lane_raw;
    always_comb begin
      lane_raw = '0;
      case (mode)
        MD_INDEP: begin
          if (wid == WD_36) begin
            lane_raw[0] = p72[WW-1:0];
            lane_raw[1] = {16'h0000, p72[4*OPW-1:WW]};
          end else begin
            for (int k = 0; k < NLANE; k++) begin
              lane_raw[k] = {{(WW-ZW){prod[k][ZW-1]}}, prod[k]};
            end
          end
        end
        MD_TWO_ADD: begin
          lane_raw[0] = {{(WW-PW){p0[PW-1]}}, p0};
          lane_raw[1] = {{(WW-PW){p1[PW-1]}}, p1};
        end
        MD_FOUR_ADD, MD_MAC: lane_raw[0] = chain_sum[h];
        MD_SHIFT: lane_raw[0] = {12'h000, shres};
        MD_HIPREC: begin
          lane_raw[0] = h55[WW-1:0];
          lane_raw[1] = {{32{h55[3*OPW+1]}}, h55[3*OPW+1:WW]};
        end
        default: lane_raw = '0;
      endcase
    end

    // Rounding and saturation are bypassed in modes that do not allow them
    wire rsu_ok = cfg[F_RSU] & ((mode == MD_TWO_ADD) | sum_mode |
                  ((mode == MD_INDEP) & (wid == WD_18))); // RULE_09
    wire [NLANE-1:0] lane_sat;
    for (genvar k = 0; k < NLANE; k++) begin : g_rsu
      wire [WW:0] rr = rsu_fn(lane_raw[k], cfg[F_DROP +: 5], cfg[F_RND], cfg[F_SAT]);
      assign res[h][k*WW +: WW] = rsu_ok ? rr[WW-1:0] : lane_raw[k];
      assign lane_sat[k] = rsu_ok & rr[WW];
    end
    assign sat_ovf[h] = |lane_sat;
  end

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin // RULE_17
      cfg_ff <= {NHALF{CFG_RST}};
      run_ff <= 1'b0;
      acc_stky_ff <= '0;
      sat_stky_ff <= '0;
      rdata_ff <= '0;
      w_ff <= '0;
      tap_ff <= '0;
      chain_ff <= '0;
    end else if (clk_en) begin
      rdata_ff <= reg_rd ? rd_mux : 32'h0000_0000;
      if (cfg_wr_ok && hit_cfg0) begin
        cfg_ff[0] <= reg_wdata;
      end
      if (cfg_wr_ok && hit_cfg1) begin
        cfg_ff[1] <= reg_wdata;
      end
      if (wr_ctrl) begin
        run_ff <= reg_wdata[C_RUN];
      end
      // Sticky flags: a new event wins over a write-one-to-clear
      acc_stky_ff <= (acc_stky_ff & ~((reg_wr & hit_stat) ? reg_wdata[S_ACC +: NHALF] : 2'h0))
                     | (accept ? acc_ovf : 2'h0);
      sat_stky_ff <= (sat_stky_ff & ~((reg_wr & hit_stat) ? reg_wdata[S_SAT +: NHALF] : 2'h0))
                     | (accept ? sat_ovf : 2'h0);
      if (accept) begin
        tap_ff <= a_sel; // RULE_08
        chain_ff <= chain_sum[NHALF-1];
      end
      for (int h = 0; h < NHALF; h++) begin
        // The accumulator register is never bypassed, which breaks the feedback loop
        if (acc_clr) begin
          w_ff[h] <= '0;
        end else if (accept && is_mac[h]) begin
          w_ff[h] <= w_next[h]; // RULE_05 RULE_06
        end
      end
    end
  end

  assign reg_rdata = rdata_ff;
  assign chain_out = chain_ff;

  // ----------------------------------------------------------------
  // Result buffer
  // ----------------------------------------------------------------
  logic [BUFW-1:0] buf_dout;
  dsma_buf #(.WIDTH(BUFW)) u_buf (
    .clk(clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .in_valid(in_valid & run_ff),
    .in_ready(buf_in_ready),
    .din({acc_ovf, sat_ovf, res}),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .dout(buf_dout)
  );
  assign out_res = buf_dout[NHALF*RESW-1:0];
  assign out_sat_ovf = buf_dout[NHALF*RESW +: NHALF];
  assign out_acc_ovf = buf_dout[NHALF*RESW+NHALF +: NHALF];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_cfg_static_run: assert property (@(posedge clk) disable iff (sys_rst) // RULE_19
    run_ff && reg_wr && hit_cfg0 |=> cfg_ff[0] == $past(cfg_ff[0]))
    else $error("configuration changed while running");
  a_rdata_one_cycle: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && !reg_rd |=> reg_rdata == 32'h0000_0000)
    else $error("read data present without a read");
  a_acc_add_sum: assert property (@(posedge clk) disable iff (sys_rst) // RULE_05
    accept && is_mac[0] && !acc_sub[0] && !acc_clr
    |=> w_ff[0] == $past(w_ff[0]) + $past(zx[0]))
    else $error("accumulator did not add Z");
  a_chain_out_sum: assert property (@(posedge clk) disable iff (sys_rst) // RULE_07
    accept |=> chain_out == $past(chain_sum[1]))
    else $error("chain output not taken from second half");
  a_tap_delay_line: assert property (@(posedge clk) disable iff (sys_rst) // RULE_08
    accept ##1 (accept && cfg_ff[0][F_TAP]) |-> a_sel[1] == $past(a_sel[0]))
    else $error("tap delay line did not shift");
  a_loop_from_reg: assert property (@(posedge clk) disable iff (sys_rst) // RULE_06
    cfg_ff[0][F_LOOP] |-> b0_sel[0] == w_ff[0][WW-1:LOOP_LSB])
    else $error("loopback not taken from register");
  a_stop_no_ready: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && wr_ctrl && !reg_wdata[C_RUN] |=> !in_ready)
    else $error("ready while stopped");
endmodule : dsma_block

/* dsma_sink.sv */
// Purpose: fabric-side consumer of the result stream of the multiply-add block
// Assumes: one clock, synchronous active-high reset
// Notes: stall holds ready low so that the two-entry buffer fills up
`timescale 1ns/1ps
module dsma_sink
  import dsma_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic stall,
  input wire logic out_valid,
  input wire logic [NHALF*RESW-1:0] out_res,
  output logic out_ready,
  output logic [NHALF*RESW-1:0] got_res,
  output logic [7:0] got_cnt
);
  // Ready is registered, as slow fabric logic would drive it
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      out_ready <= 1'b0;
      got_res <= '0;
      got_cnt <= 8'h00;
    end else begin
      out_ready <= ~stall;
      if (out_valid && out_ready) begin
        got_res <= out_res;
        got_cnt <= got_cnt + 8'h01;
      end
    end
  end
endmodule : dsma_sink

/* testbench.sv */
// Purpose: self-checking bench for the two-half multiply-add block
// Assumes: operands and register strobes are driven just after the rising edge
// Notes: shift results are compared on the 32-bit vector only
`timescale 1ns/1ps
module testbench;
  import dsma_pkg::*;
  logic clk, sys_rst, reg_wr, reg_rd, in_valid, in_ready, out_valid, out_ready, stall, rdy;
  logic clk_en;
  logic [NHALF-1:0] sat_ovf, acc_ovf;
  logic [AW-1:0] reg_addr;
  logic [DW-1:0] reg_wdata, reg_rdata, d;
  logic [NHALF*NLANE*OPW-1:0] op_a, op_b;
  logic [NHALF-1:0] sign_a, sign_b;
  logic [NHALF*3-1:0] shift_op;
  logic [WW-1:0] chain_in, chain_out;
  logic [NHALF*RESW-1:0] out_res, got_res;
  logic [7:0] got_cnt;
  logic signed [OPW-1:0] la [8];
  logic signed [OPW-1:0] lb [8];
  logic signed [WW-1:0] e, w;
  logic [31:0] v, sv;
  int err_count, n_checks, op;

  dsma_block i_dut (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .in_valid(in_valid), .in_ready(in_ready), .op_a(op_a), .op_b(op_b), .sign_a(sign_a),
    .sign_b(sign_b), .shift_op(shift_op), .chain_in(chain_in), .chain_out(chain_out),
    .out_valid(out_valid), .out_ready(out_ready), .out_res(out_res), .out_sat_ovf(sat_ovf),
    .out_acc_ovf(acc_ovf));
  dsma_sink i_sink (.clk(clk), .sys_rst(sys_rst), .stall(stall), .out_valid(out_valid),
    .out_res(out_res), .out_ready(out_ready), .got_res(got_res), .got_cnt(got_cnt));

  always #5 clk = ~clk;

  // ----------------------------------------------------------------
  // Bus and stream tasks
  // ----------------------------------------------------------------
  task print_verdict;
    $display("Checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict

  task chk(input string nm, input logic [WW-1:0] exp, input logic [WW-1:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task wr(input logic [AW-1:0] a, input logic [DW-1:0] dat);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= dat;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task rd(input logic [AW-1:0] a, output logic [DW-1:0] dat);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    dat = reg_rdata;
  endtask : rd

  // Ready is combinational, so it is read once settled and held to the edge
  task send;
    int i;
    @(posedge clk);
    for (i = 0; i < 8; i++) begin
      op_a[i*OPW+:OPW] <= la[i];
      op_b[i*OPW+:OPW] <= lb[i];
    end
    in_valid <= 1'b1;
    rdy = 1'b0;
    for (i = 0; i < 50 && rdy !== 1'b1; i++) begin
      #1;
      rdy = in_ready;
      @(posedge clk);
    end
    in_valid <= 1'b0;
    chk("accept", 1, rdy);
    if (rdy !== 1'b1) print_verdict();
  endtask : send

  task waitcnt(input logic [7:0] n);
    int i;
    for (i = 0; i < 50 && got_cnt !== n; i++) @(posedge clk);
    chk("words", n, got_cnt);
    if (got_cnt !== n) print_verdict();
  endtask : waitcnt

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    clk_en = 1'b1;
    {reg_wr, reg_rd, in_valid, stall} = 4'h0;
    reg_addr = '0;
    reg_wdata = '0;
    op_a = '0;
    op_b = '0;
    shift_op = '0;
    chain_in = '0;
    sign_a = 2'b11;
    sign_b = 2'b11;
    err_count = 0;
    n_checks = 0;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    rd(OFS_CFG0, d);
    chk("cfg0 reset", 0, d);
    rd(OFS_STATUS, d);
    chk("status reset", 0, d);
    rd(8'h40, d);
    chk("unmapped", 0, d);
    wr(OFS_CFG0, 32'h0000_0021);
    wr(OFS_CFG1, 32'h0000_0002);
    wr(OFS_CTRL, 32'h0000_0001);
    wr(OFS_CFG0, 32'h0000_0003);
    rd(OFS_CFG0, d);
    chk("cfg0 locked", 32'h21, d);
    // Most negative operands push the sums to their full widths
    la = '{-3, 7, -131072, -131072, 131071, -131072, -131072, -131072};
    lb = '{1000, -5, -131072, -131072, 131071, -131072, -131072, -131072};
    send();
    waitcnt(1);
    e = la[0] * lb[0] - la[1] * lb[1];
    chk("h0 lane0", e, got_res[0+:WW]);
    e = la[2] * lb[2] + la[3] * lb[3];
    chk("h0 lane1", e, got_res[WW+:WW]);
    e = la[4] * lb[4] + la[5] * lb[5] + la[6] * lb[6] + la[7] * lb[7];
    chk("h1 sum", e, got_res[RESW+:WW]);
    chk("h1 lane1", 0, got_res[RESW+WW+:WW]);
    stall <= 1'b1;
    repeat (2) @(posedge clk);
    send();
    send();
    #1;
    chk("full ready", 0, in_ready);
    stall <= 1'b0;
    waitcnt(3);
    wr(OFS_CTRL, 32'h0000_0000);
    wr(OFS_CFG0, 32'h0000_0803);
    wr(OFS_CFG1, 32'h0000_0802);
    wr(OFS_CTRL, 32'h0000_0002);
    wr(OFS_CTRL, 32'h0000_0001);
    chain_in <= 44'h000_0001_2345;
    send();
    send();
    waitcnt(5);
    w = 2 * (la[0] * lb[0] + la[1] * lb[1] + la[2] * lb[2] + la[3] * lb[3]);
    chk("acc lane", w + chain_in, got_res[0+:WW]);
    chk("chain", w + chain_in + e, chain_out);
    rd(OFS_ACC0, d);
    chk("acc reg", w[31:0], d);
    wr(OFS_CTRL, 32'h0000_0000);
    wr(OFS_CFG0, 32'h0000_0004);
    wr(OFS_CTRL, 32'h0000_0001);
    la[0] = 18'h0_3C81;
    la[1] = 18'h0_9A5C;
    lb[0] = 18'h0_0005;
    v = 32'h9A5C_3C81;
    // Operation changes on every word to show it is not static
    for (op = 0; op < 6; op++) begin
      shift_op <= op[5:0];
      send();
      waitcnt(8'(6 + op));
      case (op)
        0, 2: sv = v << 5;
        1: sv = v >> 5;
        3: sv = $signed(v) >>> 5;
        4: sv = (v << 5) | (v >> 27);
        default: sv = (v >> 5) | (v << 27);
      endcase
      chk("shift", sv, got_res[31:0]);
    end
    // Half 1 saturates, half 0 runs plain 18-bit products with the tap line on
    wr(OFS_CTRL, 32'h0000_0000);
    wr(OFS_CFG0, 32'h0000_2110);
    wr(OFS_CFG1, 32'h0000_0502);
    wr(OFS_CTRL, 32'h0000_0001);
    stall <= 1'b1;
    send();
    #1;
    chk("head valid", 1, out_valid);
    chk("sat flag", 2'b10, sat_ovf);
    chk("acc flag", 0, acc_ovf);
    @(posedge clk);
    stall <= 1'b0;
    waitcnt(12);
    e = la[0] * lb[0];
    chk("indep lane0", e, got_res[0+:WW]);
    e = la[0] * lb[1];
    chk("tap lane1", e, got_res[WW+:WW]);
    e = la[2] * lb[3];
    chk("tap lane3", e, got_res[3*WW+:WW]);
    chk("h1 sat", SAT_MAX[WW-1:0], got_res[RESW+:WW]);
    rd(OFS_STATUS, d);
    chk("status sat", 32'h0000_0011, d);
    // A write while the enable is low must be ignored
    clk_en <= 1'b0;
    wr(OFS_CTRL, 32'h0000_0000);
    clk_en <= 1'b1;
    rd(OFS_CTRL, d);
    chk("frozen run", 1, d);
    print_verdict();
  end
endmodule : testbench
